//--- design/timer8_cfg.svh
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH

// Register byte offsets on the Avalon-MM bus
`define OFS_CONTROL 5'h00
`define OFS_COUNT 5'h04
`define OFS_COMPARE 5'h08
`define OFS_IRQ_MASK 5'h0C
`define OFS_FLAGS 5'h10
`define OFS_PIN_CTRL 5'h14
`define OFS_STATUS 5'h18

// Control register fields
`define CTL_WAVE_LSB 0
`define CTL_ACTION_LSB 2
`define CTL_CLKSEL_LSB 4
`define CTL_FORCE_BIT 7

// Mask, flag, pin and status bits
`define BIT_OVF 0
`define BIT_CMP 1
`define PIN_DIR_BIT 0
`define PIN_PORT_BIT 1
`define STS_OC_BIT 0
`define STS_DIR_BIT 1

// Counter extremes, reset values and output action codes
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_ONE 8'h01
`define RST_BYTE 8'h00
`define CLKSEL_STOP 3'h0
`define ACTION_NONE 2'h0
`define ACTION_TOGGLE 2'h1
`define ACTION_CLEAR 2'h2
`define ACTION_SET 2'h3

`endif

//--- design/timer8_compare.sv
`timescale 1ns/1ps
`include "timer8_cfg.svh"

// Function
// - Clock source select zero stops all ticks; other values pass ticks.
// - Each tick clears, increments or decrements count as mode demands.
// - CPU reads and writes count anytime; CPU write beats tick update.
// - Only waveform mode shapes counting; output action never does.
// - Count equal to compare sets match flag on that tick.
// - Compare request when flag, enable and global enable; ack clears.
// - Writing one to compare flag bit clears it.
// - Pulse-width modes buffer compare value, loaded only at maximum (0xFF).
// - Buffered modes access the buffer; others access live compare.
// - Force strobe in non-PWM modes applies action, no flag, no reload.
// - Count write blocks compare match for the next tick.
// - Compare output state survives waveform mode changes.
// - Reset clears compare output state to zero.
// - Output action is unbuffered; governs the next match after write.
// - Nonzero action overrides port value; direction from direction bit.
// - Action zero leaves output state unchanged at matches.
// - Non-PWM: set, clear, toggle; PWM: inverted or non-inverted, and fast PWM also toggles at match.
// - Normal mode counts up, wraps 0xFF to 0x00, writes anytime.
// - Overflow flag set as count becomes zero; counting never clears.
// - Overflow interrupt execution clears the overflow flag.
// - Bottom is 0x00, maximum 0xFF; top is maximum or compare.
// - Mode 2 clears counter when it equals compare value.
// - Mode 3 counts bottom to maximum then restarts.
// - Mode 1 counts up to maximum then down to bottom.
module timer8_compare
  import timer8_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic [3:0] byteenable,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic timer_tick,
  input wire logic global_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic [2:0] clock_source_select,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  output logic pin_out,
  output logic pin_oe
);

  wave_mode_e waveform_mode_select;
  logic [1:0] output_action_select;
  logic [7:0] count_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buf;
  logic count_up;
  logic match_block;
  logic compare_output;
  logic compare_irq_enable;
  logic overflow_irq_enable;
  logic compare_match_flag;
  logic overflow_flag;
  logic pin_direction_bit;
  logic port_value;

  logic req;
  logic wr_fire;
  logic wr_lane;
  logic tick;
  logic pwm_mode;
  logic match;
  logic at_max;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic force_hit;
  logic [1:0] oc_action;
  logic [7:0] next_count;
  logic next_up;
  logic next_oc;
  logic [31:0] next_readdata;

  assign req = read | write;
  // A write lands on the edge where waitrequest is sampled low
  assign wr_fire = write & ~waitrequest;
  assign wr_lane = wr_fire & byteenable[0];
  assign wr_ctrl = wr_lane & (address == `OFS_CONTROL);
  assign wr_count = wr_lane & (address == `OFS_COUNT);
  assign wr_compare = wr_lane & (address == `OFS_COMPARE);
  assign wr_flags = wr_lane & (address == `OFS_FLAGS);

  assign tick = timer_tick & (clock_source_select != `CLKSEL_STOP);
  assign pwm_mode = (waveform_mode_select == mode_phase_pwm) |
                    (waveform_mode_select == mode_fast_pwm);
  assign at_max = (count_value == `COUNT_MAX);
  assign match = tick & (count_value == compare_value) & ~match_block;
  assign force_hit = wr_ctrl & writedata[`CTL_FORCE_BIT] & ~pwm_mode;
  // A force takes the action written together with the strobe
  assign oc_action = force_hit ? writedata[`CTL_ACTION_LSB +: 2] :
                     output_action_select;

  // Bus handshake: one wait cycle, then a single-cycle acceptance
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(req & waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      `OFS_CONTROL: begin
        next_readdata[1:0] = waveform_mode_select;
        next_readdata[3:2] = output_action_select;
        next_readdata[6:4] = clock_source_select;
      end
      `OFS_COUNT: next_readdata[7:0] = count_value;
      `OFS_COMPARE: begin
        next_readdata[7:0] = pwm_mode ? compare_buf : compare_value;
      end
      `OFS_IRQ_MASK: begin
        next_readdata[`BIT_OVF] = overflow_irq_enable;
        next_readdata[`BIT_CMP] = compare_irq_enable;
      end
      `OFS_FLAGS: begin
        next_readdata[`BIT_OVF] = overflow_flag;
        next_readdata[`BIT_CMP] = compare_match_flag;
      end
      `OFS_PIN_CTRL: begin
        next_readdata[`PIN_DIR_BIT] = pin_direction_bit;
        next_readdata[`PIN_PORT_BIT] = port_value;
      end
      `OFS_STATUS: begin
        next_readdata[`STS_OC_BIT] = compare_output;
        next_readdata[`STS_DIR_BIT] = count_up;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // Control register; force strobe is not stored and reads as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waveform_mode_select <= mode_normal;
      output_action_select <= `ACTION_NONE;
      clock_source_select <= `CLKSEL_STOP;
    end else if (wr_ctrl) begin
      waveform_mode_select <= wave_mode_e'(writedata[`CTL_WAVE_LSB +: 2]);
      output_action_select <= writedata[`CTL_ACTION_LSB +: 2];
      clock_source_select <= writedata[`CTL_CLKSEL_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_irq_enable <= 1'b0;
      compare_irq_enable <= 1'b0;
      pin_direction_bit <= 1'b0;
      port_value <= 1'b0;
    end else if (wr_lane) begin
      if (address == `OFS_IRQ_MASK) begin
        overflow_irq_enable <= writedata[`BIT_OVF];
        compare_irq_enable <= writedata[`BIT_CMP];
      end
      if (address == `OFS_PIN_CTRL) begin
        pin_direction_bit <= writedata[`PIN_DIR_BIT];
        port_value <= writedata[`PIN_PORT_BIT];
      end
    end
  end

  // Counting sequence depends on waveform mode only
  always_comb begin
    next_count = count_value;
    next_up = count_up;
    case (waveform_mode_select)
      mode_normal: begin
        next_count = count_value + `COUNT_ONE;
        next_up = 1'b1;
      end
      mode_clear_on_match: begin
        next_up = 1'b1;
        if (count_value == compare_value) begin
          next_count = `COUNT_BOTTOM;
        end else begin
          next_count = count_value + `COUNT_ONE;
        end
      end
      mode_fast_pwm: begin
        next_count = count_value + `COUNT_ONE;
        next_up = 1'b1;
      end
      mode_phase_pwm: begin
        if (count_up) begin
          if (at_max) begin
            next_up = 1'b0;
            next_count = count_value - `COUNT_ONE;
          end else begin
            next_count = count_value + `COUNT_ONE;
          end
        end else begin
          if (count_value == `COUNT_BOTTOM) begin
            next_up = 1'b1;
            next_count = count_value + `COUNT_ONE;
          end else begin
            next_count = count_value - `COUNT_ONE;
          end
        end
      end
      default: begin
        next_count = count_value;
        next_up = count_up;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_value <= `RST_BYTE;
      count_up <= 1'b1;
    end else if (wr_count) begin
      count_value <= writedata[7:0];
    end else if (tick) begin
      count_value <= next_count;
      count_up <= next_up;
    end
  end

  // Blocks the match in the first tick after a count write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      match_block <= 1'b0;
    end else if (wr_count) begin
      match_block <= 1'b1;
    end else if (tick) begin
      match_block <= 1'b0;
    end
  end

  // Compare buffer and live compare register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_buf <= `RST_BYTE;
    end else if (wr_compare) begin
      compare_buf <= writedata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_value <= `RST_BYTE;
    end else if (wr_compare & ~pwm_mode) begin
      compare_value <= writedata[7:0];
    end else if (pwm_mode & tick & at_max) begin
      compare_value <= compare_buf;
    end
  end

  // Compare output state
  always_comb begin
    next_oc = compare_output;
    case (waveform_mode_select)
      mode_normal, mode_clear_on_match: begin
        if (match | force_hit) begin
          case (oc_action)
            `ACTION_TOGGLE: next_oc = ~compare_output;
            `ACTION_CLEAR: next_oc = 1'b0;
            `ACTION_SET: next_oc = 1'b1;
            default: next_oc = compare_output;
          endcase
        end
      end
      mode_fast_pwm: begin
        if (match) begin
          case (output_action_select)
            `ACTION_TOGGLE: next_oc = ~compare_output;
            `ACTION_CLEAR: next_oc = 1'b0;
            `ACTION_SET: next_oc = 1'b1;
            default: next_oc = compare_output;
          endcase
        end else if (tick & at_max) begin
          if (output_action_select == `ACTION_CLEAR) begin
            next_oc = 1'b1;
          end else if (output_action_select == `ACTION_SET) begin
            next_oc = 1'b0;
          end
        end
      end
      mode_phase_pwm: begin
        if (match) begin
          if (output_action_select == `ACTION_CLEAR) begin
            next_oc = ~count_up;
          end else if (output_action_select == `ACTION_SET) begin
            next_oc = count_up;
          end
        end
      end
      default: next_oc = compare_output;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_output <= 1'b0;
    end else begin
      compare_output <= next_oc;
    end
  end

  // Flags: hardware set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_match_flag <= 1'b0;
    end else if (match) begin
      compare_match_flag <= 1'b1;
    end else if (compare_irq_ack) begin
      compare_match_flag <= 1'b0;
    end else if (wr_flags & writedata[`BIT_CMP]) begin
      compare_match_flag <= 1'b0;
    end
  end

  logic ovf_event;
  always_comb begin
    case (waveform_mode_select)
      mode_phase_pwm: ovf_event = ~count_up & (count_value == `COUNT_ONE);
      default: ovf_event = at_max;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (tick & ovf_event & ~wr_count) begin
      overflow_flag <= 1'b1;
    end else if (overflow_irq_ack) begin
      overflow_flag <= 1'b0;
    end else if (wr_flags & writedata[`BIT_OVF]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_irq_req <= 1'b0;
      overflow_irq_req <= 1'b0;
    end else begin
      compare_irq_req <= compare_match_flag & compare_irq_enable &
                         global_irq_enable;
      overflow_irq_req <= overflow_flag & overflow_irq_enable &
                          global_irq_enable;
    end
  end

  // Pin override by compare output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= (output_action_select != `ACTION_NONE) ?
                 compare_output : port_value;
      pin_oe <= pin_direction_bit;
    end
  end

endmodule : timer8_compare

//--- design/timer8_pkg.sv
package timer8_pkg;

  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_phase_pwm = 2'b01,
    mode_clear_on_match = 2'b10,
    mode_fast_pwm = 2'b11
  } wave_mode_e;

endpackage : timer8_pkg

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "timer8_cfg.svh"
module testbench import timer8_pkg::*;;
  logic core_clk = 0, rst = 1, read = 0, write = 0, timer_tick = 0;
  logic global_irq_enable = 0, compare_irq_ack = 0, overflow_irq_ack = 0;
  logic [4:0] address = 5'h00;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, compare_irq_req, overflow_irq_req, pin_out, pin_oe;
  logic [2:0] clock_source_select;
  wire [6:0] outs = {clock_source_select, compare_irq_req, overflow_irq_req,
    pin_oe, pin_out};
  int err_count = 0, n_tests = 0;
  logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
  logic [7:0] exps [5] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00};

  always #50 core_clk = ~core_clk;

  timer8_compare u_dut (.core_clk(core_clk), .rst(rst), .address(address),
    .byteenable(byteenable), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer_tick(timer_tick), .global_irq_enable(global_irq_enable),
    .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .clock_source_select(clock_source_select),
    .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
    .pin_out(pin_out), .pin_oe(pin_oe));

  task automatic finish_test;
    $display("mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= w;
    read <= ~w;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF);
    bus(1'b0, a, 8'h00);
    chk(q & {24'h0, m}, {24'h0, e});
  endtask : rc

  task automatic tk(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge core_clk);
      timer_tick <= 1'b0;
      @(posedge core_clk);
    end
  endtask : tk

  task automatic ack(input logic c);
    if (c) compare_irq_ack <= 1'b1;
    else overflow_irq_ack <= 1'b1;
    @(posedge core_clk);
    compare_irq_ack <= 1'b0;
    overflow_irq_ack <= 1'b0;
    @(posedge core_clk);
  endtask : ack

  // Output ports are compared mid-cycle, once settled
  task automatic oc(input logic [6:0] m, input logic [6:0] e);
    @(negedge core_clk);
    chk({25'h0, outs & m}, {25'h0, e});
    @(posedge core_clk);
  endtask : oc

  function automatic logic [7:0] ctl(input wave_mode_e m,
      input logic [1:0] a, input logic [2:0] s, input logic f);
    return {f, s, a, m};
  endfunction : ctl

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rc(`OFS_CONTROL, 8'h00);
    rc(`OFS_STATUS, 8'h00, 8'h01);
    rc(`OFS_FLAGS, 8'h00);
    rc(5'h1C, 8'h00);
    oc(7'h7F, 7'h00);
    wr(`OFS_COUNT, 8'h10);
    tk(3);
    rc(`OFS_COUNT, 8'h10);
    wr(`OFS_CONTROL, ctl(mode_normal, 2'h0, 3'h1, 1'b0));
    oc(7'h70, 7'h10);
    wr(`OFS_COUNT, 8'hFE);
    tk(1);
    rc(`OFS_FLAGS, 8'h00);
    tk(1);
    rc(`OFS_COUNT, 8'h00);
    rc(`OFS_FLAGS, 8'h01);
    global_irq_enable <= 1'b1;
    wr(`OFS_IRQ_MASK, 8'h01);
    oc(7'h0C, 7'h04);
    ack(1'b0);
    rc(`OFS_FLAGS, 8'h00);
    oc(7'h0C, 7'h00);
    wr(`OFS_COMPARE, 8'h05);
    wr(`OFS_COUNT, 8'h05);
    tk(1);
    rc(`OFS_FLAGS, 8'h00);
    wr(`OFS_COUNT, 8'h03);
    tk(2);
    rc(`OFS_FLAGS, 8'h00);
    tk(1);
    rc(`OFS_FLAGS, 8'h02);
    wr(`OFS_FLAGS, 8'h02);
    rc(`OFS_FLAGS, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_CONTROL, ctl(mode_normal, acts[i], 3'h0, 1'b1));
      rc(`OFS_STATUS, exps[i], 8'h01);
    end
    rc(`OFS_FLAGS, 8'h00);
    rc(`OFS_COUNT, 8'h06);
    wr(`OFS_PIN_CTRL, 8'h03);
    wr(`OFS_CONTROL, ctl(mode_normal, 2'h0, 3'h0, 1'b0));
    oc(7'h03, 7'h03);
    wr(`OFS_CONTROL, ctl(mode_normal, 2'h2, 3'h0, 1'b0));
    oc(7'h03, 7'h02);
    wr(`OFS_CONTROL, ctl(mode_normal, 2'h3, 3'h0, 1'b1));
    wr(`OFS_CONTROL, ctl(mode_fast_pwm, 2'h3, 3'h0, 1'b0));
    rc(`OFS_STATUS, 8'h01, 8'h01);
    oc(7'h03, 7'h03);
    wr(`OFS_CONTROL, ctl(mode_fast_pwm, 2'h0, 3'h1, 1'b0));
    wr(`OFS_COMPARE, 8'h10);
    rc(`OFS_COMPARE, 8'h10);
    wr(`OFS_IRQ_MASK, 8'h02);
    wr(`OFS_COUNT, 8'h03);
    tk(3);
    rc(`OFS_FLAGS, 8'h02);
    oc(7'h08, 7'h08);
    ack(1'b1);
    rc(`OFS_FLAGS, 8'h00);
    wr(`OFS_COUNT, 8'hFF);
    tk(1);
    rc(`OFS_COUNT, 8'h00);
    wr(`OFS_CONTROL, ctl(mode_clear_on_match, 2'h0, 3'h1, 1'b0));
    wr(`OFS_COMPARE, 8'h03);
    wr(`OFS_COUNT, 8'h00);
    tk(4);
    rc(`OFS_COUNT, 8'h00);
    wr(`OFS_CONTROL, ctl(mode_phase_pwm, 2'h0, 3'h1, 1'b0));
    wr(`OFS_COUNT, 8'hFE);
    tk(2);
    rc(`OFS_COUNT, 8'hFE);
    rc(`OFS_STATUS, 8'h00, 8'h02);
    finish_test;
  end

  initial begin
    #1000000;
    err_count++;
    finish_test;
  end
endmodule : testbench

//--- tb/timer8_compare_props.sv
`timescale 1ns/1ps
module timer8_compare_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic timer_tick,
  input wire logic global_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic [2:0] clock_source_select,
  input wire logic compare_irq_req,
  input wire logic overflow_irq_req,
  input wire logic pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_wait_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("no ack");
  chk_wait_single: assert property (
    !waitrequest |=> waitrequest) else $error("ack too long");
  chk_read_byte: assert property (
    !waitrequest && read |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_cmp_global: assert property (
    compare_irq_req |-> $past(global_irq_enable))
    else $error("compare request without global enable");
  chk_cmp_ack: assert property (
    compare_irq_ack && !timer_tick |=> ##1 !compare_irq_req)
    else $error("compare request kept after ack");
  chk_ovf_global: assert property (
    overflow_irq_req |-> $past(global_irq_enable))
    else $error("overflow request without global enable");
  chk_ovf_ack: assert property (
    overflow_irq_ack && !timer_tick |=> ##1 !overflow_irq_req)
    else $error("overflow request kept after ack");
  chk_src_hold: assert property (
    $changed(clock_source_select) |-> $past(write) || $past(write, 2))
    else $error("source select changed without write");
  chk_dir_hold: assert property (
    $changed(pin_oe) |-> $past(write) || $past(write, 2))
    else $error("direction changed without write");
endmodule : timer8_compare_props

bind timer8_compare timer8_compare_props u_props (
  .core_clk(core_clk), .rst(rst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .timer_tick(timer_tick),
  .global_irq_enable(global_irq_enable), .compare_irq_ack(compare_irq_ack),
  .overflow_irq_ack(overflow_irq_ack),
  .clock_source_select(clock_source_select),
  .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
  .pin_oe(pin_oe));
